// ### common/dp_defines.svh
`ifndef DP_DEFINES_SVH
`define DP_DEFINES_SVH
// Status word bit positions
`define SW0_PTR_LSB 13
`define SW0_XS_BIT 12
`define SW0_SAT_BIT 11
`define SW1_PBK_LSB 13
`define SW1_TF_BIT 11
`define SW1_SXE_BIT 10
`define SW1_C_BIT 9
// Saturation values
`define ACC_POS_SAT 32'h7fff_ffff
`define ACC_NEG_SAT 32'h8000_0000
`define ACC_ZERO 32'h0000_0000
// Register byte offsets (low address bits)
`define OFS_SW0 4'h0
`define OFS_SW1 4'h4
`define OFS_ACC 4'h8
`define OFS_CUR_AR 4'hc
`define OFS_BAD 4'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// Index register number and unit step
`define AR_INDEX 3'h0
`define AR_STEP 16'h0001
`define HALF_ZERO 16'h0000
`endif

// ### common/dp_pkg.sv
`default_nettype none
package dp_pkg;
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_LOAD,
    OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_BIT, OP_ALGN
  } alu_op_t;
  typedef enum logic [2:0] {
    AR_INC, AR_DEC, AR_INC_IDX, AR_DEC_IDX, AR_ADDK, AR_SUBK
  } ar_mod_t;
  typedef enum logic [1:0] {CMP_EQ, CMP_LT, CMP_GT, CMP_NE} cmp_cond_t;
  typedef struct packed {
    logic [31:0] acc;
    logic c, xs, sat, tf, sxe;
    logic [2:0] ptr, pbk;
    logic [7:0][15:0] ar;
    logic pend_v;
    ar_mod_t pend_mod;
    logic [7:0] pend_k;
    logic dwb_v;
    logic [15:0] dwb, rd_addr, wr_addr, st_data;
    logic st_v, eq0, lt0, gt0;
    logic aw_got, w_got, awrdy, wrdy, bv, arrdy, rv;
    logic [3:0] aw_addr;
    logic [15:0] w_data;
    logic [1:0] w_strb, bresp, rresp;
    logic [31:0] rdata;
  } dp_state_t;
endpackage
`default_nettype wire

// ### design/acc_out_shifter.sv
`default_nettype none
module acc_out_shifter #(
  parameter int W = 32,
  parameter int SHW = 3
) (
  input wire logic [W-1:0] acc_in,
  input wire logic [SHW-1:0] shift_in,
  input wire logic high_in,
  output logic [W/2-1:0] half_out
);
  logic [W-1:0] shifted;
  // RQ12 copy shifted, pick half
  // RQ13 top lost, zero fill
  assign shifted = acc_in << shift_in;
  assign half_out = high_in ? shifted[W-1:W/2] : shifted[W/2-1:0];
endmodule
`default_nettype wire

// ### design/arith_datapath.sv
// Function
// RQ1: Operand from accumulator plus selected shifter.
// RQ2: Results land in accumulator; shifts, rotates.
// RQ3: Add, subtract, logic, test in one cycle.
// RQ4: Sign extend mode bit gates extension.
// RQ5: Add sets carry; shift16 no-carry keeps.
// RQ6: Subtract clears carry on borrow; exception.
// RQ7: Shift left carries MSB, right LSB.
// RQ8: Saturate mode loads extreme on overflow.
// RQ9: Overflow flag sets and stays set.
// RQ10: Test flag follows bit; align uses xor.
// RQ11: Flags and accumulator sign drive branches.
// RQ12: Store shifts copy 0-7, outputs half.
// RQ13: Shifted-out bits lost, zeros fill in.
// RQ14: Eight 16-bit address registers, parallel.
// RQ15: Three-bit pointer selects current register.
// RQ16: Current register drives read/write address.
// RQ17: Post-access step by one or index.
// RQ18: Add or subtract 8-bit instruction constant.
// RQ19: Compare result reaches test flag via bus.
// RQ20: Address math in decode; align defers.
// RQ21: Pointer load saves old value to backup.
// RQ22: Reset sets carry.
// RQ23: Index amount comes from register zero.
// RQ24: Compare condition: eq, lt, gt, ne.
`default_nettype none
`include "dp_defines.svh"
module arith_datapath
  import dp_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic op_valid_in,
  input wire alu_op_t op_in,
  input wire logic src_prod_in,
  input wire logic [15:0] in_data_in,
  input wire logic shift16_in,
  input wire logic sx_honour_in,
  input wire logic [31:0] prod_data_in,
  input wire logic [4:0] bit_sel_in,
  input wire logic store_valid_in,
  input wire logic store_high_in,
  input wire logic [2:0] store_shift_in,
  input wire logic ldst_in,
  input wire logic [15:0] ldst_word_in,
  input wire logic ptr_load_in,
  input wire logic [2:0] ptr_new_in,
  input wire logic ar_valid_in,
  input wire ar_mod_t ar_mod_in,
  input wire logic [7:0] ar_k_in,
  input wire logic ar_load_in,
  input wire logic [15:0] ar_data_in,
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic cmp_valid_in,
  input wire cmp_cond_t cmp_cond_in,
  output logic [15:0] read_address_bus_out,
  output logic [15:0] write_address_bus_out,
  output logic [15:0] data_write_bus_out,
  output logic store_valid_out,
  output logic [15:0] store_data_out,
  output logic cond_carry_out,
  output logic cond_excess_out,
  output logic cond_test_out,
  output logic acc_eq0_out,
  output logic acc_lt0_out,
  output logic acc_gt0_out,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  dp_state_t s_r, s_nxt;
  logic [31:0] opnd, res;
  logic [32:0] sum, dif;
  logic ovf, cmp_hit, ld0, ld1;
  logic [15:0] sw0, sw1, cur_ar, old_w, wd, st_half;

  function automatic logic [15:0] ar_step(ar_mod_t m, logic [15:0] v, logic [15:0] x, logic [7:0] k);
    case (m)
      AR_INC: ar_step = v + `AR_STEP;
      AR_DEC: ar_step = v - `AR_STEP;
      AR_INC_IDX: ar_step = v + x;
      AR_DEC_IDX: ar_step = v - x;
      AR_ADDK: ar_step = v + {8'h00, k};
      AR_SUBK: ar_step = v - {8'h00, k};
      default: ar_step = v;
    endcase
  endfunction

  acc_out_shifter #(.W(32), .SHW(3)) u_out_shift (
    .acc_in(s_r.acc),
    .shift_in(store_shift_in),
    .high_in(store_high_in),
    .half_out(st_half)
  );
  assign cur_ar = s_r.ar[s_r.ptr];
  // Reserved bits read zero
  assign sw0 = {s_r.ptr, s_r.xs, s_r.sat, 11'h000};
  assign sw1 = {s_r.pbk, 1'b0, s_r.tf, s_r.sxe, s_r.c, 9'h000};
  // RQ1 operand source select
  // RQ4 extension gated by mode
  assign opnd = src_prod_in ? prod_data_in : shift16_in ? {in_data_in, 16'h0000} :
                (s_r.sxe && sx_honour_in) ? {{16{in_data_in[15]}}, in_data_in} : {16'h0000, in_data_in};
  assign sum = {1'b0, s_r.acc} + {1'b0, opnd};
  assign dif = {1'b0, s_r.acc} - {1'b0, opnd};
  always_comb begin
    s_nxt = s_r;
    res = s_r.acc;
    ovf = 1'b0;
    ld0 = 1'b0;
    ld1 = 1'b0;
    wd = s_nxt.w_data;
    old_w = sw0;
    cmp_hit = 1'b0;
    ////////////////////////////////////////////////////////////////
    // Register bus slave
    if (s_r.bv && s_axi_bready) s_nxt.bv = 1'b0;
    if (s_r.rv && s_axi_rready) s_nxt.rv = 1'b0;
    // Upper address bits must be zero, else the slot is unmapped
    if (s_axi_awvalid && s_r.awrdy) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = (s_axi_awaddr[31:4] == 28'h000_0000) ? s_axi_awaddr[3:0] : `OFS_BAD;
    end
    if (s_axi_wvalid && s_r.wrdy) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata[15:0];
      s_nxt.w_strb = s_axi_wstrb[1:0];
    end
    if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bv) begin
      s_nxt.bv = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bresp = `RESP_OKAY;
      if (s_nxt.aw_addr == `OFS_SW1) old_w = sw1;
      wd = {s_nxt.w_strb[1] ? s_nxt.w_data[15:8] : old_w[15:8],
            s_nxt.w_strb[0] ? s_nxt.w_data[7:0] : old_w[7:0]};
      case (s_nxt.aw_addr)
        `OFS_SW0: ld0 = 1'b1;
        `OFS_SW1: ld1 = 1'b1;
        `OFS_ACC, `OFS_CUR_AR: ;
        default: s_nxt.bresp = `RESP_SLVERR;
      endcase
    end
    s_nxt.awrdy = !s_nxt.aw_got && !s_nxt.bv;
    s_nxt.wrdy = !s_nxt.w_got && !s_nxt.bv;
    if (s_axi_arvalid && s_r.arrdy) begin
      s_nxt.rv = 1'b1;
      s_nxt.rresp = `RESP_OKAY;
      case ((s_axi_araddr[31:4] == 28'h000_0000) ? s_axi_araddr[3:0] : `OFS_BAD)
        `OFS_SW0: s_nxt.rdata = {16'h0000, sw0};
        `OFS_SW1: s_nxt.rdata = {16'h0000, sw1};
        `OFS_ACC: s_nxt.rdata = s_r.acc;
        `OFS_CUR_AR: s_nxt.rdata = {16'h0000, cur_ar};
        default: begin
          s_nxt.rdata = `ACC_ZERO;
          s_nxt.rresp = `RESP_SLVERR;
        end
      endcase
    end
    s_nxt.arrdy = !s_nxt.rv;
    ////////////////////////////////////////////////////////////////
    // Status loads; decode load wins over the bus
    if (ldst_in) begin
      ld0 = 1'b1;
      ld1 = 1'b0;
      wd = ldst_word_in;
    end
    if (ld0) begin
      s_nxt.ptr = wd[`SW0_PTR_LSB +: 3];
      s_nxt.xs = wd[`SW0_XS_BIT];
      s_nxt.sat = wd[`SW0_SAT_BIT];
    end
    if (ld1) begin
      s_nxt.pbk = wd[`SW1_PBK_LSB +: 3];
      s_nxt.ptr = wd[`SW1_PBK_LSB +: 3];
      s_nxt.tf = wd[`SW1_TF_BIT];
      s_nxt.sxe = wd[`SW1_SXE_BIT];
      s_nxt.c = wd[`SW1_C_BIT];
    end
    ////////////////////////////////////////////////////////////////
    // Central arithmetic unit, one cycle per op
    // RQ3 single cycle ops
    if (op_valid_in) begin
      case (op_in)
        OP_ADD: begin
          res = sum[31:0];
          ovf = (s_r.acc[31] == opnd[31]) && (res[31] != s_r.acc[31]);
          // RQ5 carry on add
          if (!(shift16_in && !sum[32])) s_nxt.c = sum[32];
        end
        OP_SUB: begin
          res = dif[31:0];
          ovf = (s_r.acc[31] != opnd[31]) && (res[31] != s_r.acc[31]);
          // RQ6 carry is not-borrow
          if (!(shift16_in && !dif[32])) s_nxt.c = !dif[32];
        end
        OP_AND: res = s_r.acc & opnd;
        OP_OR: res = s_r.acc | opnd;
        OP_XOR: res = s_r.acc ^ opnd;
        OP_LOAD: res = opnd;
        // RQ7 shifted-out bit to carry
        OP_SHL: begin
          res = {s_r.acc[30:0], 1'b0};
          s_nxt.c = s_r.acc[31];
        end
        OP_SHR: begin
          res = {s_r.sxe & s_r.acc[31], s_r.acc[31:1]};
          s_nxt.c = s_r.acc[0];
        end
        OP_ROL: begin
          res = {s_r.acc[30:0], s_r.c};
          s_nxt.c = s_r.acc[31];
        end
        OP_ROR: begin
          res = {s_r.c, s_r.acc[31:1]};
          s_nxt.c = s_r.acc[0];
        end
        // RQ10 test flag sources
        OP_BIT: s_nxt.tf = opnd[bit_sel_in];
        OP_ALGN: begin
          s_nxt.tf = s_r.acc[31] ^ s_r.acc[30];
          if (!(s_r.acc[31] ^ s_r.acc[30])) res = {s_r.acc[30:0], 1'b0};
        end
        default: res = s_r.acc;
      endcase
      // RQ9 sticky overflow flag
      if (ovf) s_nxt.xs = 1'b1;
      // RQ8 saturate toward overflow sign
      if (ovf && s_r.sat) res = s_r.acc[31] ? `ACC_NEG_SAT : `ACC_POS_SAT;
      // RQ2 result into accumulator
      s_nxt.acc = res;
    end
    // RQ11 branch conditions
    s_nxt.eq0 = (s_nxt.acc == `ACC_ZERO);
    s_nxt.lt0 = s_nxt.acc[31];
    s_nxt.gt0 = !s_nxt.acc[31] && (s_nxt.acc != `ACC_ZERO);
    ////////////////////////////////////////////////////////////////
    // Store path
    s_nxt.st_v = store_valid_in;
    if (store_valid_in) s_nxt.st_data = st_half;
    ////////////////////////////////////////////////////////////////
    // Auxiliary arithmetic unit
    // RQ16 current register onto address buses
    if (mem_rd_in) s_nxt.rd_addr = cur_ar;
    if (mem_wr_in) s_nxt.wr_addr = cur_ar;
    // RQ20 deferred step lands in execute
    s_nxt.pend_v = 1'b0;
    // RQ23 index from register zero
    if (s_r.pend_v) s_nxt.ar[s_r.ptr] = ar_step(s_r.pend_mod, cur_ar, s_r.ar[`AR_INDEX], s_r.pend_k);
    if (ar_load_in) s_nxt.ar[s_r.ptr] = ar_data_in;
    // RQ14 runs beside the arithmetic unit
    if (ar_valid_in) begin
      if (op_valid_in && op_in == OP_ALGN) begin
        s_nxt.pend_v = 1'b1;
        s_nxt.pend_mod = ar_mod_in;
        s_nxt.pend_k = ar_k_in;
      end else begin
        // RQ17 post-access step, wraps
        // RQ18 constant from instruction
        s_nxt.ar[s_r.ptr] = ar_step(ar_mod_in, cur_ar, s_r.ar[`AR_INDEX], ar_k_in);
      end
    end
    // RQ15 pointer load
    // RQ21 old pointer to backup
    if (ptr_load_in && !ldst_in) begin
      s_nxt.ptr = ptr_new_in;
      s_nxt.pbk = s_r.ptr;
    end
    // RQ24 compare conditions
    case (cmp_cond_in)
      CMP_EQ: cmp_hit = cur_ar == s_r.ar[`AR_INDEX];
      CMP_LT: cmp_hit = s_r.ar[`AR_INDEX] < cur_ar;
      CMP_GT: cmp_hit = s_r.ar[`AR_INDEX] > cur_ar;
      default: cmp_hit = cur_ar != s_r.ar[`AR_INDEX];
    endcase
    // RQ19 compare result via write bus
    s_nxt.dwb_v = cmp_valid_in;
    if (cmp_valid_in) s_nxt.dwb = {15'h0000, cmp_hit};
    if (s_r.dwb_v) s_nxt.tf = s_r.dwb[0];
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s_r <= '0;
      // RQ22 carry forced high
      s_r.c <= 1'b1;
      s_r.sxe <= 1'b1;
      // Accumulator is zero during reset
      s_r.eq0 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign read_address_bus_out = s_r.rd_addr;
  assign write_address_bus_out = s_r.wr_addr;
  assign data_write_bus_out = s_r.dwb;
  assign store_valid_out = s_r.st_v;
  assign store_data_out = s_r.st_data;
  assign cond_carry_out = s_r.c;
  assign cond_excess_out = s_r.xs;
  assign cond_test_out = s_r.tf;
  assign acc_eq0_out = s_r.eq0;
  assign acc_lt0_out = s_r.lt0;
  assign acc_gt0_out = s_r.gt0;
  assign s_axi_awready = s_r.awrdy;
  assign s_axi_wready = s_r.wrdy;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bv;
  assign s_axi_arready = s_r.arrdy;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rv;
  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  carry_reset_a: assert property (srst_in |=> cond_carry_out) // RQ22
    else $error("carry not set by reset");
  add_carry_a: assert property (disable iff (srst_in) // RQ5
    op_valid_in && op_in == OP_ADD && !shift16_in && !ldst_in && !ld1 |=> s_r.c == $past(sum[32]))
    else $error("add carry wrong");
  sub_carry_a: assert property (disable iff (srst_in) // RQ6
    op_valid_in && op_in == OP_SUB && !ldst_in && !ld1 && dif[32] |=> !s_r.c)
    else $error("borrow did not clear carry");
  rotate_carry_a: assert property (disable iff (srst_in) // RQ7
    op_valid_in && op_in == OP_ROL && !ld1 |=> s_r.c == $past(s_r.acc[31]) && s_r.acc[0] == $past(s_r.c))
    else $error("rotate left wrong");
  sat_value_a: assert property (disable iff (srst_in) // RQ8
    op_valid_in && ovf && s_r.sat |=> s_r.acc == ($past(s_r.acc[31]) ? `ACC_NEG_SAT : `ACC_POS_SAT))
    else $error("saturation value wrong");
  excess_sticky_a: assert property (disable iff (srst_in) // RQ9
    s_r.xs && !ld0 |=> s_r.xs)
    else $error("overflow flag dropped");
  store_half_a: assert property (disable iff (srst_in) // RQ12
    store_valid_in |=> store_valid_out && store_data_out ==
      ($past(store_high_in) ? $past(s_r.acc << store_shift_in) >> 16 : $past(s_r.acc << store_shift_in)) % 65536)
    else $error("store half wrong");
  read_addr_a: assert property (disable iff (srst_in) // RQ16
    mem_rd_in |=> read_address_bus_out == $past(cur_ar))
    else $error("read address not current register");
  ptr_backup_a: assert property (disable iff (srst_in) // RQ21
    ptr_load_in && !ldst_in && !ld1 |=> s_r.pbk == $past(s_r.ptr) && s_r.ptr == $past(ptr_new_in))
    else $error("pointer backup wrong");
  cmp_test_a: assert property (disable iff (srst_in) // RQ19
    cmp_valid_in && !ld1 ##1 !(op_valid_in && (op_in == OP_BIT || op_in == OP_ALGN)) |=>
      cond_test_out == $past(cmp_hit, 2))
    else $error("compare result not in test flag");
  bus_resp_a: assert property (disable iff (srst_in)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  sat_cov: cover property (op_valid_in && ovf && s_r.sat);
  store_cov: cover property (store_valid_in && store_high_in && store_shift_in != 3'h0);
  cmp_cov: cover property (cmp_valid_in ##2 cond_test_out);
  align_cov: cover property (op_valid_in && op_in == OP_ALGN && ar_valid_in);
endmodule
`default_nettype wire

// ### tb/data_mem_model.sv
`default_nettype none
module data_mem_model (
  input wire logic mclk_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [15:0] peek_addr_in,
  output logic [15:0] peek_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unwritten words stay unknown
  logic [15:0] mem [65536];
  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end
  assign peek_data_out = mem[peek_addr_in];
endmodule
`default_nettype wire

// ### tb/cpu_arith_and_aux_address_datapath_tb_top.sv
`default_nettype none
`include "dp_defines.svh"
module cpu_arith_and_aux_address_datapath_tb_top
  import dp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in, srst_in, op_valid_in, src_prod_in, shift16_in, sx_honour_in, store_valid_in, store_high_in;
  logic ldst_in, ptr_load_in, ar_valid_in, ar_load_in, mem_rd_in, mem_wr_in, cmp_valid_in;
  alu_op_t op_in;
  ar_mod_t ar_mod_in;
  cmp_cond_t cmp_cond_in;
  logic [15:0] in_data_in, ldst_word_in, ar_data_in, read_address_bus_out, write_address_bus_out;
  logic [15:0] data_write_bus_out, store_data_out, peek_data;
  logic [31:0] prod_data_in, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_v;
  logic [4:0] bit_sel_in;
  logic [2:0] store_shift_in, ptr_new_in;
  logic [7:0] ar_k_in;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic store_valid_out, cond_carry_out, cond_excess_out, cond_test_out, acc_eq0_out, acc_lt0_out, acc_gt0_out;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors = 0;
  int samples_checked = 0;

  arith_datapath dut (.*);
  data_mem_model mem (.mclk_in, .wr_en_in(store_valid_out), .wr_addr_in(write_address_bus_out),
    .wr_data_in(store_data_out), .peek_addr_in(write_address_bus_out), .peek_data_out(peek_data));

  initial begin
    mclk_in = 1'h0;
    forever #5 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad = 1'h0;
    logic wd = 1'h0;
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge mclk_in);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge mclk_in); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er, "bresp");
  endtask

  task automatic axi_rd(input logic [31:0] a);
    @(posedge mclk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge mclk_in); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk_in); while (s_axi_rvalid !== 1'h1);
    rd_v = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    axi_rd(a);
    chk(rd_v & m, e, s);
    chk(rd_r, `RESP_OKAY, "rresp");
  endtask

  // s[0]: operand<<16, s[1]: honour sign ext; c/v code 2 skips
  task automatic step(input alu_op_t o, input logic [15:0] d, input logic [1:0] s, input logic [31:0] a,
                      input logic ka, input logic [1:0] c, input logic [1:0] v);
    @(posedge mclk_in);
    op_valid_in <= 1'h1;
    op_in <= o;
    in_data_in <= d;
    shift16_in <= s[0];
    sx_honour_in <= s[1];
    @(posedge mclk_in);
    op_valid_in <= 1'h0;
    #1;
    if (!c[1]) chk(cond_carry_out, c[0], "carry");
    if (!v[1]) chk(cond_excess_out, v[0], "excess");
    if (ka) begin
      chk({acc_eq0_out, acc_lt0_out, acc_gt0_out}, {a == 32'h0, a[31], !a[31] && a != 32'h0}, "sign");
      rdchk(`OFS_ACC, 32'hffff_ffff, a, "acc");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({cond_carry_out, cond_excess_out, cond_test_out, acc_eq0_out}, 4'h9, "reset flags");
    rdchk(`OFS_SW0, 32'hffff_ffff, 32'h0000_0000, "sw0 reset");
    rdchk(`OFS_SW1, 32'hffff_ffff, 32'h0000_0600, "sw1 reset");
    axi_rd(32'h0000_0010);
    chk({rd_r, rd_v}, {`RESP_SLVERR, 32'h0000_0000}, "unmapped read");
    axi_wr(32'h0000_0020, 32'h0000_ffff, `RESP_SLVERR);
  endtask

  task automatic t_carry();
    step(OP_LOAD, 16'h0001, 2'h0, 32'h0000_0001, 1'h1, 2'h2, 2'h0);
    step(OP_ADD, 16'h0001, 2'h0, 32'h0000_0002, 1'h1, 2'h0, 2'h0);
    step(OP_SUB, 16'h0001, 2'h0, 32'h0000_0001, 1'h1, 2'h1, 2'h0);
    step(OP_SUB, 16'h0002, 2'h0, 32'hffff_ffff, 1'h1, 2'h0, 2'h0);
    step(OP_ADD, 16'h0001, 2'h1, 32'h0000_ffff, 1'h1, 2'h1, 2'h0);
    step(OP_ADD, 16'h0001, 2'h1, 32'h0001_ffff, 1'h1, 2'h1, 2'h0);
    step(OP_SUB, 16'h0002, 2'h1, 32'hffff_ffff, 1'h1, 2'h0, 2'h0);
    step(OP_SUB, 16'h0001, 2'h1, 32'hfffe_ffff, 1'h1, 2'h0, 2'h0);
  endtask

  task automatic t_sat();
    step(OP_LOAD, 16'h7fff, 2'h1, 32'h7fff_0000, 1'h1, 2'h2, 2'h0);
    step(OP_OR, 16'hffff, 2'h0, 32'h7fff_ffff, 1'h1, 2'h2, 2'h0);
    step(OP_ADD, 16'h0001, 2'h0, 32'h8000_0000, 1'h1, 2'h0, 2'h1);
    step(OP_ADD, 16'h0000, 2'h0, 32'h8000_0000, 1'h1, 2'h0, 2'h1);
    axi_wr(`OFS_SW0, 32'h0000_0800, `RESP_OKAY);
    rdchk(`OFS_SW0, 32'hffff_ffff, 32'h0000_0800, "sw0 rw");
    step(OP_LOAD, 16'h7fff, 2'h1, 32'h7fff_0000, 1'h1, 2'h2, 2'h0);
    step(OP_OR, 16'hffff, 2'h0, 32'h7fff_ffff, 1'h1, 2'h2, 2'h0);
    step(OP_ADD, 16'h0001, 2'h0, 32'h7fff_ffff, 1'h1, 2'h0, 2'h1);
    axi_wr(`OFS_SW0, 32'h0000_0800, `RESP_OKAY);
    step(OP_LOAD, 16'h8000, 2'h1, 32'h8000_0000, 1'h1, 2'h2, 2'h0);
    step(OP_SUB, 16'h0001, 2'h0, 32'h8000_0000, 1'h1, 2'h1, 2'h1);
    axi_wr(`OFS_SW0, 32'h0000_0000, `RESP_OKAY);
    step(OP_LOAD, 16'hffff, 2'h2, 32'hffff_ffff, 1'h1, 2'h2, 2'h0);
    axi_wr(`OFS_SW1, 32'h0000_0200, `RESP_OKAY);
    step(OP_LOAD, 16'hffff, 2'h2, 32'h0000_ffff, 1'h1, 2'h2, 2'h0);
    axi_wr(`OFS_SW1, 32'h0000_0600, `RESP_OKAY);
  endtask

  task automatic t_shift();
    step(OP_LOAD, 16'h8000, 2'h1, 32'h8000_0000, 1'h1, 2'h2, 2'h2);
    step(OP_OR, 16'h0001, 2'h0, 32'h8000_0001, 1'h1, 2'h2, 2'h2);
    step(OP_SHL, 16'h0000, 2'h0, 32'h0000_0002, 1'h1, 2'h1, 2'h2);
    step(OP_SHR, 16'h0000, 2'h0, 32'h0000_0001, 1'h1, 2'h0, 2'h2);
    step(OP_SHR, 16'h0000, 2'h0, 32'h0000_0000, 1'h1, 2'h1, 2'h2);
    step(OP_LOAD, 16'h8000, 2'h1, 32'h8000_0000, 1'h1, 2'h2, 2'h2);
    step(OP_ROL, 16'h0000, 2'h0, 32'h0000_0001, 1'h1, 2'h1, 2'h2);
    step(OP_LOAD, 16'h0002, 2'h0, 32'h0000_0002, 1'h1, 2'h2, 2'h2);
    step(OP_ROR, 16'h0000, 2'h0, 32'h8000_0001, 1'h1, 2'h0, 2'h2);
    step(OP_LOAD, 16'h00ff, 2'h0, 32'h0000_00ff, 1'h1, 2'h2, 2'h2);
    step(OP_XOR, 16'h0f0f, 2'h0, 32'h0000_0ff0, 1'h1, 2'h2, 2'h2);
    step(OP_AND, 16'h00f0, 2'h0, 32'h0000_00f0, 1'h1, 2'h2, 2'h2);
  endtask

  task automatic t_test();
    step(OP_BIT, 16'h0004, 2'h0, 32'h0000_00f0, 1'h1, 2'h2, 2'h2);
    chk(cond_test_out, 1'h1, "bit set");
    step(OP_BIT, 16'h0000, 2'h0, 32'h0000_00f0, 1'h1, 2'h2, 2'h2);
    chk(cond_test_out, 1'h0, "bit clear");
    step(OP_LOAD, 16'h4000, 2'h1, 32'h4000_0000, 1'h1, 2'h2, 2'h2);
    step(OP_ALGN, 16'h0000, 2'h0, 32'h4000_0000, 1'h1, 2'h2, 2'h2);
    chk(cond_test_out, 1'h1, "align differ");
    step(OP_LOAD, 16'h2000, 2'h1, 32'h2000_0000, 1'h1, 2'h2, 2'h2);
    step(OP_ALGN, 16'h0000, 2'h0, 32'h4000_0000, 1'h1, 2'h2, 2'h2);
    chk(cond_test_out, 1'h0, "align same");
  endtask

  task automatic store(input logic hi, input logic [2:0] sh, input logic [15:0] e);
    @(posedge mclk_in);
    store_valid_in <= 1'h1;
    store_high_in <= hi;
    store_shift_in <= sh;
    @(posedge mclk_in);
    store_valid_in <= 1'h0;
    #1;
    chk({store_valid_out, store_data_out}, {1'h1, e}, "store");
    @(posedge mclk_in);
    #1;
    chk({store_valid_out, peek_data}, {1'h0, e}, "mem word");
  endtask

  task automatic t_store();
    step(OP_LOAD, 16'h1234, 2'h1, 32'h1234_0000, 1'h1, 2'h2, 2'h2);
    step(OP_OR, 16'h5678, 2'h0, 32'h1234_5678, 1'h1, 2'h2, 2'h2);
    store(1'h1, 3'h4, 16'h2345);
    store(1'h0, 3'h7, 16'h3c00);
    store(1'h1, 3'h0, 16'h1234);
    axi_wr(`OFS_ACC, 32'h0000_0000, `RESP_OKAY);
    rdchk(`OFS_ACC, 32'hffff_ffff, 32'h1234_5678, "acc kept");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic aux(input logic pl, input logic [2:0] p, input logic al, input logic [15:0] ad,
                     input logic sv, input ar_mod_t m, input logic [7:0] k, input logic [1:0] rw);
    @(posedge mclk_in);
    {ptr_load_in, ptr_new_in, ar_load_in, ar_data_in, ar_valid_in, ar_mod_in, ar_k_in} <= {pl, p, al, ad, sv, m, k};
    {mem_rd_in, mem_wr_in} <= rw;
    @(posedge mclk_in);
    {ptr_load_in, ar_load_in, ar_valid_in, mem_rd_in, mem_wr_in} <= 5'h00;
    #1;
  endtask

  task automatic cmp(input cmp_cond_t cc, input logic e);
    @(posedge mclk_in);
    cmp_valid_in <= 1'h1;
    cmp_cond_in <= cc;
    @(posedge mclk_in);
    cmp_valid_in <= 1'h0;
    #1;
    chk(data_write_bus_out, {15'h0000, e}, "compare bus");
    @(posedge mclk_in);
    #1;
    chk(cond_test_out, e, "compare flag");
  endtask

  task automatic t_aux();
    aux(1'h0, 3'h0, 1'h1, 16'h0010, 1'h0, AR_INC, 8'h00, 2'h0);
    aux(1'h1, 3'h5, 1'h0, 16'h0000, 1'h0, AR_INC, 8'h00, 2'h0);
    aux(1'h1, 3'h3, 1'h0, 16'h0000, 1'h0, AR_INC, 8'h00, 2'h0);
    rdchk(`OFS_SW0, 32'h0000_e000, 32'h0000_6000, "pointer");
    rdchk(`OFS_SW1, 32'h0000_e000, 32'h0000_a000, "backup");
    aux(1'h0, 3'h0, 1'h1, 16'hffff, 1'h0, AR_INC, 8'h00, 2'h0);
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h1, AR_INC, 8'h00, 2'h2);
    chk(read_address_bus_out, 16'hffff, "read address");
    rdchk(`OFS_CUR_AR, 32'hffff_ffff, 32'h0000_0000, "wrap");
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h1, AR_DEC, 8'h00, 2'h1);
    chk(write_address_bus_out, 16'h0000, "write address");
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h1, AR_ADDK, 8'h81, 2'h0);
    rdchk(`OFS_CUR_AR, 32'hffff_ffff, 32'h0000_0080, "add const");
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h1, AR_SUBK, 8'hff, 2'h0);
    rdchk(`OFS_CUR_AR, 32'hffff_ffff, 32'h0000_ff81, "sub const");
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h1, AR_INC_IDX, 8'h00, 2'h0);
    rdchk(`OFS_CUR_AR, 32'hffff_ffff, 32'h0000_ff91, "inc index");
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h1, AR_DEC_IDX, 8'h00, 2'h0);
    rdchk(`OFS_CUR_AR, 32'hffff_ffff, 32'h0000_ff81, "dec index");
    for (int i = 0; i < 4; i++) begin
      cmp(cmp_cond_t'(i), i[0]);
    end
    // Align op with a step: the step must land one edge late
    @(posedge mclk_in);
    {op_valid_in, op_in, ar_valid_in, ar_mod_in} <= {1'h1, OP_ALGN, 1'h1, AR_INC};
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h0, AR_INC, 8'h00, 2'h2);
    chk(read_address_bus_out, 16'hff81, "deferred step");
    aux(1'h0, 3'h0, 1'h0, 16'h0000, 1'h0, AR_INC, 8'h00, 2'h2);
    chk(read_address_bus_out, 16'hff82, "step landed");
    aux(1'h1, 3'h0, 1'h0, 16'h0000, 1'h0, AR_INC, 8'h00, 2'h0);
    cmp(CMP_EQ, 1'h1);
  endtask

  initial begin
    {srst_in, op_valid_in, src_prod_in, shift16_in, sx_honour_in, store_valid_in, store_high_in} <= 7'h40;
    {ldst_in, ptr_load_in, ar_valid_in, ar_load_in, mem_rd_in, mem_wr_in, cmp_valid_in} <= 7'h00;
    {op_in, ar_mod_in, cmp_cond_in, in_data_in, ldst_word_in, ar_data_in} <= '0;
    {prod_data_in, store_shift_in, ptr_new_in, ar_k_in} <= '0;
    bit_sel_in <= 5'h02;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
    repeat (16) @(posedge mclk_in);
    srst_in <= 1'h0;
    @(posedge mclk_in);
    #1;
    t_reset();
    t_carry();
    t_sat();
    t_shift();
    t_test();
    t_store();
    t_aux();
    tally_and_finish();
  end

  // Run takes under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
